/* File: uabw_pkg.sv */
/*
 * Shared constants for the auto-baud measurement and wake-on-break block:
 * register byte offsets, field positions, reset values and divider counts.
 * Assumes a 32-bit AHB-Lite register bus with word-aligned registers.
 */
package uabw_pkg;
	// Register byte offsets
	localparam logic [7:0] RATE_CONTROL_OFS = 8'h00;
	localparam logic [7:0] DIV_LOW_OFS = 8'h04;
	localparam logic [7:0] DIV_HIGH_OFS = 8'h08;
	localparam logic [7:0] RX_DATA_OFS = 8'h0c;

	// Field positions in rate_control_reg
	localparam int AUTOBAUD_ENABLE_BIT = 0;
	localparam int WAKE_ENABLE_BIT = 1;
	localparam int OVERFLOW_BIT = 2;
	localparam int WIDE_DIV_BIT = 3;
	localparam int HIGH_RATE_BIT = 4;
	localparam int SYNC_MODE_BIT = 5;
	localparam int RX_IDLE_BIT = 6;
	localparam int RX_FLAG_BIT = 7;

	// Reset values
	localparam logic [15:0] DIVISOR_RESET = 16'h0000;
	localparam logic [15:0] MEASURE_START = 16'h0001;
	localparam logic [7:0] RX_DATA_RESET = 8'h00;
	localparam logic [2:0] EDGE_COUNT_RESET = 3'h0;
	localparam logic [2:0] LAST_EDGE = 3'h5;

	// Measurement clock divider top values, one less than core clock cycles per counter tick
	localparam logic [8:0] DIV_SLOW = 9'h1ff;
	localparam logic [8:0] DIV_MID = 9'h07f;
	localparam logic [8:0] DIV_FAST = 9'h01f;

	typedef enum logic [1:0] {
		UABW_IDLE = 2'b00,
		UABW_WAIT_START = 2'b01,
		UABW_WAIT_EDGE = 2'b10,
		UABW_MEASURE = 2'b11
	} uabw_state_t;
endpackage

/* File: uabw_autobaud_wake.sv */
/*
 * Auto-baud measurement and wake-on-break logic of an asynchronous serial
 * receiver, with its control registers on an AHB-Lite slave port.
 * Assumes one 100 MHz clock, a serial input pin from outside the clock
 * domain, and a sleep level from the power controller on the same clock.
 * The master is expected to tie hready to hreadyout and move whole words.
 */
// Chosen here: the placing of the registers and register access over AHB-Lite.
`timescale 1ns/100ps
`default_nettype none

// How it works
// - In auto-baud mode the serial line gates the counter to time a 55h character.
// - Setting autobaud_enable starts measurement; receiver held idle meanwhile.
// - Counting starts at the first rising edge after the start bit.
// - Fifth rising edge: keep count, clear autobaud_enable, set receive_flag.
// - Reading receive_data_reg clears receive_flag; data may be discarded.
// - Both divisor registers form one 16-bit counter during measurement.
// - Counter ticks at core clock /512, /128 or /32 by the two select bits.
// - Counter starts at one; software subtracts one afterwards.
// - With wake enabled too, measure the character after the break.
// - Set autobaud_overflow if the counter passes 16 bits before edge five.
// - After overflow keep counting; fifth edge completes as normal.
// - Software clears overflow directly, only once autobaud_enable is clear.
// - Wake enabled: reception disabled, falling edge is the wake event.
// - Wake event sets receive_flag; reading receive_data_reg clears it.
// - Rising edge ending the break clears wake_on_break_enable.
// - Wake detection works only in asynchronous configuration.
// - In sleep the rate generator stops and no reception takes place.
// - A nonzero character wakes at its start bit low time; rest is a fragment.
module uabw_autobaud_wake (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire logic serialIn,
	input wire logic sleepMode,
	output logic receiveFlag,
	output logic wakeRequest
);
	import uabw_pkg::*;

	// Reset and serial line
	logic rstSync1, rstSync2;
	logic rxMeta, rxSync, rxPrev;
	logic rxRise, rxFall;
	logic autobaudEnable, wakeEnable, autobaudOverflow;
	logic wideDivSelect, highRateSelect, syncMode;
	logic [15:0] divisor;
	logic [7:0] rxData;
	// Measurement
	logic [8:0] prescale, prescaleTop;
	logic tick;
	logic [2:0] edgeCount;
	logic wakeSeen;
	uabw_state_t state, next_state;
	logic measuring, finish, receiverIdle;
	// Register bus
	logic addrValid, wrPending;
	logic [7:0] wrAddr;
	logic rdStrobe, rxRead;
	logic [31:0] next_rdata;
	logic wrCtrl, wrLow, wrHigh;
	logic wakeEvent, breakEnd;

	// Reset release through two flops
	// Assertion stays immediate; only the release is aligned to the clock
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			rstSync1 <= 1'b0;
			rstSync2 <= 1'b0;
		end else begin
			rstSync1 <= 1'b1;
			rstSync2 <= rstSync1;
		end
	end

	// Serial pin synchroniser; edges are taken only behind the second flop
	// Flops reset high, the idle level, so no false edge follows reset
	always_ff @(posedge clk or negedge rstSync2) begin
		if (!rstSync2) begin
			rxMeta <= 1'b1;
			rxSync <= 1'b1;
			rxPrev <= 1'b1;
		end else begin
			rxMeta <= serialIn;
			rxSync <= rxMeta;
			rxPrev <= rxSync;
		end
	end

	// One-cycle edge pulses, two clocks after the pin moves
	assign rxRise = rxSync & ~rxPrev;
	assign rxFall = ~rxSync & rxPrev;

	// AHB-Lite: zero wait states, read data registered at the address phase
	// Only haddr[31:8] of zero decodes, so aliases above the map read as holes
	// hresp is tied OKAY: every slot answers, holes included
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign addrValid = hsel & htrans[1] & hready;
	assign rdStrobe = addrValid & ~hwrite;
	// A read of the data register is what clears receive_flag
	assign rxRead = rdStrobe & (haddr[7:0] == RX_DATA_OFS) & (haddr[31:8] == 24'h000000);

	// Word for the read in the address phase; bits above each field read zero
	always_comb begin
		next_rdata = 32'h00000000;
		if (haddr[31:8] == 24'h000000) begin
			case (haddr[7:0])
				RATE_CONTROL_OFS: begin
					next_rdata[AUTOBAUD_ENABLE_BIT] = autobaudEnable;
					next_rdata[WAKE_ENABLE_BIT] = wakeEnable;
					next_rdata[OVERFLOW_BIT] = autobaudOverflow;
					next_rdata[WIDE_DIV_BIT] = wideDivSelect;
					next_rdata[HIGH_RATE_BIT] = highRateSelect;
					next_rdata[SYNC_MODE_BIT] = syncMode;
					next_rdata[RX_IDLE_BIT] = receiverIdle;
					next_rdata[RX_FLAG_BIT] = receiveFlag;
				end
				DIV_LOW_OFS: next_rdata[7:0] = divisor[7:0];
				DIV_HIGH_OFS: next_rdata[7:0] = divisor[15:8];
				RX_DATA_OFS: next_rdata[7:0] = rxData;
				default: next_rdata = 32'h00000000;
			endcase
		end
	end

	// Held until the next read, so a late data phase still sees it
	always_ff @(posedge clk or negedge rstSync2) begin
		if (!rstSync2) begin
			hrdata <= 32'h00000000;
		end else if (rdStrobe) begin
			hrdata <= next_rdata;
		end
	end

	// Data follow one cycle after the address, so the target is kept here
	always_ff @(posedge clk or negedge rstSync2) begin
		if (!rstSync2) begin
			wrPending <= 1'b0;
			wrAddr <= 8'h00;
		end else begin
			wrPending <= addrValid & hwrite & (haddr[31:8] == 24'h000000);
			wrAddr <= haddr[7:0];
		end
	end

	// Write strobes stand in the data phase, when hwdata is valid
	assign wrCtrl = wrPending & (wrAddr == RATE_CONTROL_OFS);
	assign wrLow = wrPending & (wrAddr == DIV_LOW_OFS);
	assign wrHigh = wrPending & (wrAddr == DIV_HIGH_OFS);

	// Configuration bits written by software
	// They set the measurement rate and whether the link is synchronous
	always_ff @(posedge clk or negedge rstSync2) begin
		if (!rstSync2) begin
			wideDivSelect <= 1'b0;
			highRateSelect <= 1'b0;
			syncMode <= 1'b0;
		end else if (wrCtrl) begin
			wideDivSelect <= hwdata[WIDE_DIV_BIT];
			highRateSelect <= hwdata[HIGH_RATE_BIT];
			syncMode <= hwdata[SYNC_MODE_BIT];
		end
	end

	// Measurement clock: one eighth of the normal base clock
	// Stored as top values, one less than the divide ratio
	always_comb begin
		case ({wideDivSelect, highRateSelect})
			2'b00: prescaleTop = DIV_SLOW;
			2'b11: prescaleTop = DIV_FAST;
			default: prescaleTop = DIV_MID;
		endcase
	end

	// Prescaler is held at zero in sleep, as the block's clocks would be stopped
	// Restart at zero on entry so the first tick falls one period after edge one
	always_ff @(posedge clk or negedge rstSync2) begin
		if (!rstSync2) begin
			prescale <= 9'h000;
		end else if (sleepMode || state != UABW_MEASURE) begin
			prescale <= 9'h000;
		end else if (prescale >= prescaleTop) begin
			prescale <= 9'h000;
		end else begin
			prescale <= prescale + 9'h001;
		end
	end

	// One-cycle pulse at the top of each prescaler period
	assign tick = (state == UABW_MEASURE) && !sleepMode && (prescale >= prescaleTop);

	// Measurement sequencer. Waits while wake is armed so the break is skipped.
	// Clearing autobaud_enable at any step drops back to idle, the abort path
	// A line already low at enable is ignored until it rises and falls again
	always_comb begin
		next_state = state;
		case (state)
			UABW_IDLE: begin
				if (autobaudEnable && !wakeEnable && !syncMode) begin
					next_state = UABW_WAIT_START;
				end
			end
			UABW_WAIT_START: begin
				if (!autobaudEnable) begin
					next_state = UABW_IDLE;
				end else if (rxFall) begin
					next_state = UABW_WAIT_EDGE;
				end
			end
			UABW_WAIT_EDGE: begin
				if (!autobaudEnable) begin
					next_state = UABW_IDLE;
				end else if (rxRise) begin
					next_state = UABW_MEASURE;
				end
			end
			UABW_MEASURE: begin
				if (!autobaudEnable || finish) begin
					next_state = UABW_IDLE;
				end
			end
			default: next_state = UABW_IDLE;
		endcase
	end

	// State only; the outputs decode it
	always_ff @(posedge clk or negedge rstSync2) begin
		if (!rstSync2) begin
			state <= UABW_IDLE;
		end else begin
			state <= next_state;
		end
	end

	assign measuring = (state == UABW_MEASURE);
	// Edge five closes the eighth bit period of the sync character
	assign finish = measuring && rxRise && (edgeCount == LAST_EDGE - 3'h1);
	// Flag reads high in idle and whenever wake is armed, so it reads low during a run only while wake is not armed
	assign receiverIdle = (state == UABW_IDLE) || wakeEnable;

	// Rising edges counted from the first one after the start bit
	// Cleared in idle so each run counts afresh
	always_ff @(posedge clk or negedge rstSync2) begin
		if (!rstSync2) begin
			edgeCount <= EDGE_COUNT_RESET;
		end else if (state == UABW_WAIT_EDGE && rxRise) begin
			edgeCount <= 3'h1;
		end else if (measuring && rxRise) begin
			edgeCount <= edgeCount + 3'h1;
		end else if (state == UABW_IDLE) begin
			edgeCount <= EDGE_COUNT_RESET;
		end
	end

	// Divisor pair: software value, or one 16-bit counter while measuring
	// Software writes land only in idle, so a run's count stays whole
	// The count wraps past ffff; the overflow flag keeps the record
	always_ff @(posedge clk or negedge rstSync2) begin
		if (!rstSync2) begin
			divisor <= DIVISOR_RESET;
		end else if (state == UABW_WAIT_EDGE && rxRise) begin
			divisor <= MEASURE_START;
		end else if (measuring) begin
			if (tick && !finish) begin
				divisor <= divisor + 16'h0001;
			end
		end else if (state == UABW_IDLE) begin
			if (wrLow) begin
				divisor[7:0] <= hwdata[7:0];
			end
			if (wrHigh) begin
				divisor[15:8] <= hwdata[7:0];
			end
		end
	end

	// Enables: hardware clears take priority over a software write
	// Limitation: no asynchronous path, so the clock must run during sleep
	// Wake fires once per arming; wakeSeen masks later falls
	assign wakeEvent = wakeEnable && !syncMode && !wakeSeen && rxFall;
	assign breakEnd = wakeEnable && wakeSeen && rxRise;

	// Completion beats a software write in the same cycle
	always_ff @(posedge clk or negedge rstSync2) begin
		if (!rstSync2) begin
			autobaudEnable <= 1'b0;
		end else if (finish) begin
			autobaudEnable <= 1'b0;
		end else if (wrCtrl) begin
			autobaudEnable <= hwdata[AUTOBAUD_ENABLE_BIT];
		end
	end

	// Cleared by the rising edge that ends the break
	always_ff @(posedge clk or negedge rstSync2) begin
		if (!rstSync2) begin
			wakeEnable <= 1'b0;
		end else if (breakEnd) begin
			wakeEnable <= 1'b0;
		end else if (wrCtrl) begin
			wakeEnable <= hwdata[WAKE_ENABLE_BIT];
		end
	end

	// Remembers that the falling wake edge came, so only the ending rise clears
	always_ff @(posedge clk or negedge rstSync2) begin
		if (!rstSync2) begin
			wakeSeen <= 1'b0;
		end else if (!wakeEnable) begin
			wakeSeen <= 1'b0;
		end else if (wakeEvent) begin
			wakeSeen <= 1'b1;
		end
	end

	// Overflow: set wins; a software clear only lands once the enable is clear
	// Starting at one, overflow takes 65535 ticks, so it shows only on very slow lines
	always_ff @(posedge clk or negedge rstSync2) begin
		if (!rstSync2) begin
			autobaudOverflow <= 1'b0;
		end else if (measuring && tick && !finish && divisor == 16'hffff) begin
			autobaudOverflow <= 1'b1;
		end else if (wrCtrl && !autobaudEnable) begin
			autobaudOverflow <= hwdata[OVERFLOW_BIT];
		end
	end

	// Receive flag: set by completion or wake; set wins over the read clear
	// Set winning keeps an event that meets a read in the same cycle
	always_ff @(posedge clk or negedge rstSync2) begin
		if (!rstSync2) begin
			receiveFlag <= 1'b0;
		end else if (finish || wakeEvent) begin
			receiveFlag <= 1'b1;
		end else if (rxRead) begin
			receiveFlag <= 1'b0;
		end
	end

	// No data path here: the data register holds zero for discarding reads
	// Normal reception is outside this block
	// Kept as a flop so a read of it always has a defined value
	always_ff @(posedge clk or negedge rstSync2) begin
		if (!rstSync2) begin
			rxData <= RX_DATA_RESET;
		end else begin
			rxData <= RX_DATA_RESET;
		end
	end

	// Wake request to the power controller follows the flag while asleep
	// Registered so the power controller sees no glitch from the edge logic
	always_ff @(posedge clk or negedge rstSync2) begin
		if (!rstSync2) begin
			wakeRequest <= 1'b0;
		end else begin
			wakeRequest <= sleepMode & (receiveFlag | wakeEvent);
		end
	end
endmodule
`default_nettype wire

/* File: uabw_autobaud_wake_sva.sv */
/*
 * Checker for the auto-baud and wake block, bound to its top module.
 * Assumes one clock and the asynchronous active-low reset.
 */
`timescale 1ns/100ps
`default_nettype none
module uabw_autobaud_wake_sva (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic hready,
	input wire logic [31:0] hrdata,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic serialIn,
	input wire logic sleepMode,
	input wire logic receiveFlag,
	input wire logic wakeRequest
);
	logic prevIn;
	logic [3:0] quiet;
	logic rdData;
	assign rdData = hsel && htrans[1] && hready && !hwrite && haddr == 32'hc;
	// Line edges reach the flags late, so reads are judged on a quiet line only
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			prevIn <= 1'b1;
			quiet <= 4'h0;
		end else begin
			prevIn <= serialIn;
			quiet <= (serialIn != prevIn) ? 4'h0 : quiet + {3'h0, quiet != 4'hf};
		end
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!arst_n);
	a_bus_okay: assert property (hreadyout && !hresp)
		else $error("bus answer not zero-wait OKAY");
	a_rx_data_zero: assert property (rdData |=> hrdata == 32'h0)
		else $error("receive data read not zero");
	a_byte_wide: assert property (hrdata[31:8] == 24'h0)
		else $error("read data upper bits set");
	a_flag_clear_read: assert property (rdData && quiet >= 4'h8 |=> !receiveFlag)
		else $error("flag not cleared by data read");
	a_flag_holds: assert property (receiveFlag && !rdData |=> receiveFlag)
		else $error("flag dropped without read");
	a_flag_from_edge: assert property ($rose(receiveFlag) |-> quiet <= 4'h8)
		else $error("flag rose without line edge");
	a_wake_flag_sleep: assert property (sleepMode && receiveFlag |=> wakeRequest)
		else $error("no wake request in sleep");
	a_wake_only_sleep: assert property (wakeRequest |-> $past(sleepMode))
		else $error("wake request while awake");
	c_measure: cover property ($rose(receiveFlag) && !sleepMode);
	c_wake: cover property ($rose(wakeRequest));
	c_read: cover property (rdData && receiveFlag);
endmodule
bind uabw_autobaud_wake uabw_autobaud_wake_sva chk (.clk, .arst_n, .hsel, .haddr, .htrans,
	.hwrite, .hready, .hrdata, .hreadyout, .hresp, .serialIn, .sleepMode, .receiveFlag,
	.wakeRequest);
`default_nettype wire

/* File: uabw_serial_tx.sv */
/*
 * Remote asynchronous transmitter model driving the serial line.
 * Assumes callers start its tasks from the core clock; line idles high.
 */
`timescale 1ns/100ps
`default_nettype none
module uabw_serial_tx (
	input wire logic clk,
	output logic serialLine
);
	initial serialLine = 1'b1;
	task automatic hold(input logic v, input int n);
		serialLine <= v;
		repeat (n) @(posedge clk);
	endtask
	// Start bit, eight data bits first bit first, stop bit
	task automatic sendByte(input logic [7:0] b, input int bitClks);
		@(posedge clk);
		hold(1'b0, bitClks);
		for (int i = 0; i < 8; i++) begin
			hold(b[i], bitClks);
		end
		hold(1'b1, bitClks);
	endtask
	task automatic sendBreak(input int bitClks);
		@(posedge clk);
		hold(1'b0, 13 * bitClks);
		hold(1'b1, 2 * bitClks);
	endtask
endmodule
`default_nettype wire

/* File: uabw_autobaud_wake_test.sv */
/*
 * Self-checking bench for the auto-baud and wake block.
 * Assumes a 100 MHz clock and zero-wait AHB-Lite answers.
 */
`timescale 1ns/100ps
`default_nettype none
module uabw_autobaud_wake_test;
	import uabw_pkg::*;
	logic clk = 1'b0;
	logic arst_n = 1'b0;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0] htrans = 2'b00;
	logic hwrite = 1'b0;
	logic [31:0] hwdata = 32'h0;
	logic sleepMode = 1'b0;
	logic serialIn;
	logic [31:0] hrdata;
	logic hreadyout;
	logic hresp;
	logic receiveFlag;
	logic wakeRequest;
	logic [31:0] rd;
	int fails = 0;
	int total_checks = 0;
	int cycles = 0;
	always #5 clk = ~clk;
	uabw_serial_tx tx (.clk(clk), .serialLine(serialIn));
	uabw_autobaud_wake dut (.clk(clk), .arst_n(arst_n), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .serialIn(serialIn),
		.sleepMode(sleepMode), .receiveFlag(receiveFlag), .wakeRequest(wakeRequest));
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		hsel <= 1'b1;
		htrans <= 2'b10;
		hwrite <= w;
		haddr <= {24'h0, a};
		do @(posedge clk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= d;
		do @(posedge clk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
			fails++;
		end
	endtask
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	always @(posedge clk) begin
		cycles++;
		if (cycles == 80000) begin
			fails++;
			end_of_test();
		end
	end
	task automatic testReset();
		xfer(1'b0, RATE_CONTROL_OFS, 32'h0);
		check(rd, 32'h1 << RX_IDLE_BIT);
		xfer(1'b0, DIV_LOW_OFS, 32'h0);
		check(rd, {24'h0, DIVISOR_RESET[7:0]});
		// Unmapped place: write ignored, reads zero
		xfer(1'b1, 8'h10, 32'hff);
		xfer(1'b0, 8'h10, 32'h0);
		check(rd, 32'h0);
	endtask
	// Eight bit periods of 5 ticks: start at one, no tick taken on the closing edge
	task automatic measureCheck(input int bitClks);
		tx.sendByte(8'h55, bitClks);
		check(receiveFlag, 1'b1);
		xfer(1'b0, RATE_CONTROL_OFS, 32'h0);
		check(rd[0], 1'b0);
		xfer(1'b0, DIV_HIGH_OFS, 32'h0);
		check(rd, 32'h0);
		xfer(1'b0, DIV_LOW_OFS, 32'h0);
		check(rd, 32'd40);
		xfer(1'b0, RX_DATA_OFS, 32'h0);
		check(receiveFlag, 1'b0);
	endtask
	task automatic testMeasure(input logic [1:0] m);
		int bitClks;
		bitClks = (m == 2'b00) ? 2560 : ((m == 2'b11) ? 160 : 640);
		xfer(1'b1, RATE_CONTROL_OFS, {27'h0, m[0], m[1], 3'h1});
		measureCheck(bitClks);
	endtask
	// Overflow cannot be cleared while a run is enabled
	task automatic testAbort();
		xfer(1'b1, RATE_CONTROL_OFS, 32'h4);
		xfer(1'b1, RATE_CONTROL_OFS, 32'h5);
		xfer(1'b1, RATE_CONTROL_OFS, 32'h1);
		xfer(1'b0, RATE_CONTROL_OFS, 32'h0);
		check(rd[2:0], 3'h5);
		xfer(1'b1, RATE_CONTROL_OFS, 32'h0);
		xfer(1'b0, RATE_CONTROL_OFS, 32'h0);
		check(rd[2:0], 3'h4);
		xfer(1'b1, RATE_CONTROL_OFS, 32'h0);
		xfer(1'b0, RATE_CONTROL_OFS, 32'h0);
		check(rd[2:0], 3'h0);
	endtask
	task automatic testWake();
		xfer(1'b0, RATE_CONTROL_OFS, 32'h0);
		check(rd[RX_IDLE_BIT], 1'b1);
		xfer(1'b1, RATE_CONTROL_OFS, 32'h1b);
		sleepMode <= 1'b1;
		tx.sendBreak(160);
		check(receiveFlag, 1'b1);
		check(wakeRequest, 1'b1);
		sleepMode <= 1'b0;
		xfer(1'b0, RATE_CONTROL_OFS, 32'h0);
		check(rd[1:0], 2'b01);
		xfer(1'b0, RX_DATA_OFS, 32'h0);
		measureCheck(160);
	endtask
	task automatic testSync();
		xfer(1'b1, RATE_CONTROL_OFS, 32'h22);
		tx.sendBreak(160);
		check(receiveFlag, 1'b0);
		xfer(1'b0, RATE_CONTROL_OFS, 32'h0);
		check(rd[WAKE_ENABLE_BIT], 1'b1);
		xfer(1'b1, RATE_CONTROL_OFS, 32'h0);
	endtask
	initial begin
		repeat (4) @(posedge clk);
		arst_n <= 1'b1;
		repeat (3) @(posedge clk);
		testReset();
		for (int m = 0; m < 4; m++) begin
			testMeasure(m[1:0]);
		end
		testAbort();
		testWake();
		testSync();
		end_of_test();
	end
endmodule
`default_nettype wire
